// *** design/prc_defines.vh ***
// constants for the phy reset, power-down and led control block
`ifndef PRC_DEFINES_VH
`define PRC_DEFINES_VH
`define PRC_CLK_MHZ 200
`define PRC_RST_MIN_NS 1000
`define PRC_RST_CYC ((`PRC_RST_MIN_NS * `PRC_CLK_MHZ + 999) / 1000)
`define PRC_CNT_W 8
`define PRC_ADDR_W 4
`define PRC_ADDR_CTRL 4'h0
`define PRC_ADDR_IRQ_EN 4'h1
`define PRC_ADDR_IRQ_ST 4'h2
`define PRC_ADDR_STRAP 4'h3
`define PRC_ADDR_STATUS 4'h4
`define PRC_CTRL_PIN_IRQ 0
`define PRC_CTRL_LED_ACT 1
`define PRC_CTRL_LED_COL 2
`define PRC_CTRL_RESET 8'h00
`define PRC_IRQ_W 8
`define PRC_STRAP_W 8
`define PRC_BLINK_W 23
`define PRC_BLINK_BIT 22
`endif

// *** design/prc_sync2.v ***
// two flip-flop synchroniser for one level
module prc_sync2 (
   // clock and reset
   input wire i_sys_clk,
   input wire i_rst,
   input wire i_rst_val,
   // level
   input wire i_d,
   output wire o_q
);
   reg meta_q;
   reg sync_q;
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         meta_q <= i_rst_val;
         sync_q <= i_rst_val;
      end else begin
         meta_q <= i_d;
         sync_q <= meta_q;
      end
   end
   assign o_q = sync_q;
endmodule

// *** design/prc_top.v ***
// phy reset, strap latch, irq/power-down pin, led and line pair control
//Behaviour
//RULE1 - low reset pin for 1us resets all
//RULE2 - reset returns every register to initial value; the output registers reset on i_rst only, not on the reset pin
//RULE3 - straps are latched again each reset
//RULE4 - shared pin is power-down until software selects
//RULE5 - low pin in power-down mode powers down
//RULE6 - irq mode drives pin low on irq
//RULE7 - irq output is open drain only
//RULE8 - link mode led on while link good
//RULE9 - activity mode blinks on tx/rx activity
//RULE10 - led goes to led or collision pin
//RULE11 - host gives 25 or 50 MHz clock
//RULE12 - tx pair follows negotiated speed
//RULE13 - auto crossover swaps the line pairs
//RULE14 - reset and power-down inputs are synchronised
//
// The strobed register port and the register offsets are this design's own decisions.
`include "prc_defines.vh"
module prc_top (
   // clock and reset
   input wire i_sys_clk,
   input wire i_rst,
   // device reset pin, active low
   input wire i_reset_pin_n,
   // strap pins
   input wire [`PRC_STRAP_W-1:0] i_straps,
   // shared irq or power-down pin
   input wire i_irq_or_powerdown_pin,
   output wire o_irq_or_powerdown_pin,
   output wire o_irq_or_powerdown_pin_oe,
   // events and status
   input wire [`PRC_IRQ_W-1:0] i_irq_events,
   input wire i_link_good,
   input wire i_tx_active,
   input wire i_rx_active,
   input wire i_speed_100,
   input wire i_mdix_swap,
   input wire i_rmii_mode,
   // outputs to the pads and core
   output reg o_multi_purpose_led_out,
   output reg o_col_pin_led,
   output reg o_led_on_col,
   output reg o_powerdown,
   output reg o_core_reset,
   output reg o_line_tx_100,
   output reg o_line_pairs_swapped,
   // register port
   input wire [`PRC_ADDR_W-1:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [7:0] o_rdata
);
   wire reset_pin_n_s;
   wire pwdn_pin_s;
   reg [`PRC_CNT_W-1:0] low_cnt_q;
   reg dev_rst_q;
   reg [7:0] ctrl_q;
   reg [`PRC_IRQ_W-1:0] irq_en_q;
   reg [`PRC_IRQ_W-1:0] irq_st_q;
   reg [`PRC_STRAP_W-1:0] strap_q;
   reg [`PRC_BLINK_W-1:0] blink_q;
   wire soft_rst;
   wire irq_clr;
   wire led_val;
   wire irq_out;

   // reset pin idles high, power-down pin idles high through its pull-up
   prc_sync2 u_sync_rst (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_rst_val(1'b1),
      .i_d(i_reset_pin_n),
      .o_q(reset_pin_n_s)
   ); // RULE14
   prc_sync2 u_sync_pwdn (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_rst_val(1'b1),
      .i_d(i_irq_or_powerdown_pin),
      .o_q(pwdn_pin_s)
   ); // RULE14

   // glitches shorter than the minimum low time are ignored
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         low_cnt_q <= {`PRC_CNT_W{1'b0}};
         dev_rst_q <= 1'b1;
      end else if (reset_pin_n_s) begin
         low_cnt_q <= {`PRC_CNT_W{1'b0}};
         dev_rst_q <= 1'b0;
      end else if (low_cnt_q < `PRC_RST_CYC - 1) begin
         low_cnt_q <= low_cnt_q + 1'b1;
      end else begin
         dev_rst_q <= 1'b1; // RULE1
      end
   end
   assign soft_rst = i_rst | dev_rst_q;

   // registers, all back to reset values on either reset
   assign irq_clr = i_rd && (i_addr == `PRC_ADDR_IRQ_ST);
   always @(posedge i_sys_clk) begin
      if (soft_rst) begin
         ctrl_q <= `PRC_CTRL_RESET; // RULE2 RULE4
         irq_en_q <= {`PRC_IRQ_W{1'b0}};
         irq_st_q <= {`PRC_IRQ_W{1'b0}};
         blink_q <= {`PRC_BLINK_W{1'b0}};
      end else begin
         if (i_wr && (i_addr == `PRC_ADDR_CTRL)) begin
            ctrl_q <= i_wdata;
         end
         if (i_wr && (i_addr == `PRC_ADDR_IRQ_EN)) begin
            irq_en_q <= i_wdata;
         end
         // set wins over read clear
         irq_st_q <= (irq_clr ? {`PRC_IRQ_W{1'b0}} : irq_st_q) | i_irq_events;
         blink_q <= blink_q + 1'b1;
      end
   end

   // straps sampled throughout reset, final value held at release
   always @(posedge i_sys_clk) begin
      if (soft_rst) begin
         strap_q <= i_straps; // RULE3
      end
   end

   assign irq_out = ctrl_q[`PRC_CTRL_PIN_IRQ] && |(irq_st_q & irq_en_q);
   assign o_irq_or_powerdown_pin = 1'b0; // RULE7
   assign o_irq_or_powerdown_pin_oe = irq_out; // RULE6
   // blink only while link good, like a typical activity led
   assign led_val = ctrl_q[`PRC_CTRL_LED_ACT] ?
      (i_link_good && !((i_tx_active || i_rx_active) && blink_q[`PRC_BLINK_BIT])) : // RULE9
      i_link_good; // RULE8

   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_multi_purpose_led_out <= 1'b0;
         o_col_pin_led <= 1'b0;
         o_led_on_col <= 1'b0;
         o_powerdown <= 1'b0;
         o_core_reset <= 1'b1;
         o_line_tx_100 <= 1'b0;
         o_line_pairs_swapped <= 1'b0;
         o_rdata <= 8'h00;
      end else begin
         o_multi_purpose_led_out <= led_val && !ctrl_q[`PRC_CTRL_LED_COL]; // RULE10
         o_col_pin_led <= led_val && ctrl_q[`PRC_CTRL_LED_COL]; // RULE10
         o_led_on_col <= ctrl_q[`PRC_CTRL_LED_COL];
         o_powerdown <= !ctrl_q[`PRC_CTRL_PIN_IRQ] && !pwdn_pin_s && !dev_rst_q; // RULE5
         o_core_reset <= dev_rst_q;
         o_line_tx_100 <= i_speed_100; // RULE12
         o_line_pairs_swapped <= i_mdix_swap; // RULE13
         o_rdata <= 8'h00;
         if (i_rd) begin
            case (i_addr)
               `PRC_ADDR_CTRL: o_rdata <= ctrl_q;
               `PRC_ADDR_IRQ_EN: o_rdata <= irq_en_q;
               `PRC_ADDR_IRQ_ST: o_rdata <= irq_st_q;
               `PRC_ADDR_STRAP: o_rdata <= strap_q;
               `PRC_ADDR_STATUS: o_rdata <= {3'h0, i_rmii_mode, i_mdix_swap, i_speed_100, pwdn_pin_s, i_link_good};
               default: o_rdata <= 8'h00;
            endcase
         end
      end
   end
endmodule

// *** bench/prc_top_props.sv ***
// assertions on the ports of the phy control block
module prc_top_props (
   input logic i_sys_clk, i_rst, i_reset_pin_n, i_irq_or_powerdown_pin, o_irq_or_powerdown_pin,
   input logic i_link_good, i_speed_100, o_multi_purpose_led_out, o_col_pin_led, o_led_on_col,
   input logic o_powerdown, o_core_reset, o_line_tx_100
);
   logic [7:0] low_q;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   // saturates so a long hold never wraps into a short one
   always @(posedge i_sys_clk) low_q <= i_reset_pin_n ? 8'h00 : low_q + 8'(low_q != 8'hFF);
   sequence s_pin_high;
      i_reset_pin_n [*6];
   endsequence
   a_od_low: assert property (!o_irq_or_powerdown_pin) else $error("pin high");
   a_rst_long: assert property (low_q == 8'hD2 |-> o_core_reset) else $error("no reset");
   a_rst_short: assert property ($rose(o_core_reset) |-> low_q > 8'hBE) else $error("early reset");
   a_rst_release: assert property (s_pin_high |-> !o_core_reset) else $error("reset held");
   a_pd_cause: assert property ($rose(o_powerdown) |-> !$past(i_irq_or_powerdown_pin, 2)) else $error("pd");
   a_led_link: assert property (o_multi_purpose_led_out || o_col_pin_led |-> $past(i_link_good)) else $error("led");
   a_led_route: assert property (o_led_on_col && $stable(o_led_on_col) |-> !o_multi_purpose_led_out) else $error("rt");
   a_tx_speed: assert property (!$past(o_core_reset) |-> o_line_tx_100 == $past(i_speed_100)) else $error("spd");
endmodule
bind prc_top prc_top_props u_prc_top_props (.*);

// *** bench/prc_host_model.sv ***
// host beside the shared pin and the reset pin
module prc_host_model (
   input logic pd, rq, o_irq_or_powerdown_pin_oe,
   output logic i_irq_or_powerdown_pin, i_reset_pin_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // either side may pull low, the pull-up wins otherwise
   assign i_irq_or_powerdown_pin = !(pd || o_irq_or_powerdown_pin_oe);
   assign i_reset_pin_n = !rq;
endmodule

// *** bench/tb_prc_top.sv ***
// self-checking bench of the phy control block
module tb_prc_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_sys_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, pd = 0, rq = 0, i_link_good = 1, i_speed_100 = 1;
   logic i_tx_active = 0, i_rx_active = 0, i_mdix_swap = 0, i_rmii_mode = 0, i_reset_pin_n, i_irq_or_powerdown_pin;
   logic o_irq_or_powerdown_pin, o_irq_or_powerdown_pin_oe, o_multi_purpose_led_out, o_col_pin_led, o_led_on_col;
   logic o_powerdown, o_core_reset, o_line_tx_100, o_line_pairs_swapped;
   logic [7:0] i_straps = 8'hA5, i_irq_events = 8'h00, i_wdata = 8'h00, o_rdata;
   logic [3:0] i_addr = 4'h0;
   int n_errors = 0, n_compared = 0;
   wire [7:0] pins = {o_powerdown, o_irq_or_powerdown_pin_oe, i_irq_or_powerdown_pin, o_led_on_col,
      o_col_pin_led, o_multi_purpose_led_out, o_line_tx_100, o_line_pairs_swapped};
   prc_top u_prc_top (.*);
   prc_host_model u_prc_host_model (.*);
   initial forever #2.5 i_sys_clk = !i_sys_clk;
   task cyc(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask
   task chk(input bit rd, input logic [7:0] e);
      logic [7:0] s;
      @(negedge i_sys_clk);
      s = rd ? o_rdata : pins;
      n_compared++;
      if (s !== e) begin
         n_errors++;
         $display("Error %0t %h %h", $time, s, e);
      end
      @(posedge i_sys_clk);
   endtask
   task acc(input bit w, input logic [3:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_wr <= w;
      i_rd <= !w;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr <= 0;
      i_rd <= 0;
      if (!w) chk(1, d);
   endtask
   task test_done;
      if (n_errors == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      cyc(16);
      i_rst <= 0;
      cyc(8);
      chk(0, 8'h26);
      acc(0, 4'h3, 8'hA5);
      acc(0, 4'hF, 8'h00);
      pd <= 1;
      cyc(4);
      chk(0, 8'h86);
      pd <= 0;
      acc(1, 4'h1, 8'h01);
      acc(1, 4'h0, 8'h01);
      i_irq_events <= 8'h03;
      cyc(1);
      i_irq_events <= 8'h00;
      chk(0, 8'h46);
      acc(0, 4'h2, 8'h03);
      chk(0, 8'h26);
      acc(1, 4'h0, 8'h06);
      cyc(2);
      chk(0, 8'h3A);
      // activity early in the blink period keeps the led lit
      i_tx_active <= 1;
      cyc(2);
      chk(0, 8'h3A);
      i_tx_active <= 0;
      i_link_good <= 0;
      i_speed_100 <= 0;
      i_mdix_swap <= 1;
      cyc(2);
      chk(0, 8'h31);
      acc(0, 4'h4, 8'h0A);
      acc(1, 4'h0, 8'h01);
      rq <= 1;
      cyc(150);
      rq <= 0;
      cyc(8);
      acc(0, 4'h0, 8'h01);
      i_straps <= 8'h3C;
      rq <= 1;
      cyc(215);
      rq <= 0;
      cyc(8);
      acc(0, 4'h0, 8'h00);
      acc(0, 4'h3, 8'h3C);
      test_done;
   end
endmodule
